/* File: design/dtcs_pkg.sv */
package dtcs_pkg;
    // control register fields
    localparam int CTL_ABORT_BIT   = 31;
    localparam int CTL_MONSEL_BIT  = 29;
    localparam int CTL_TOZ_BIT     = 25;
    localparam int CTL_DBE_BIT     = 13;
    localparam int CTL_DBR_BIT     = 12;
    localparam int CTL_OVC_LSB     = 5;
    localparam int CTL_EIC_LSB     = 3;
    localparam int CTL_TM_LSB      = 0;
    localparam logic [31:0] CTL_WMASK = 32'ha20031ff;
    localparam logic [31:0] CTL_RESET = 32'h00000000;
    localparam logic [31:0] STS_RESET = 32'h00000000;
    // status register fields
    localparam int STS_TBF_BIT  = 28;
    localparam int STS_EXB_BIT  = 27;
    localparam int STS_ACK_BIT  = 26;
    localparam int STS_ZOP_BIT  = 25;
    localparam int STS_INC_BIT  = 24;
    localparam int STS_CMP_LSB  = 8;
    localparam int STS_OCD_BIT  = 5;
    localparam int STS_SLP_BIT  = 4;
    localparam int STS_HWB_BIT  = 2;
    localparam int STS_SWB_BIT  = 1;
    localparam int STS_SSS_BIT  = 0;
    localparam logic [31:0] STS_RMASK = 32'h1f00ff37;
    // overrun control encodings
    localparam logic [2:0] OVC_MSG    = 3'h0;
    localparam logic [2:0] OVC_BR_OWN = 3'h1;
    localparam logic [2:0] OVC_DT_OWN = 3'h2;
    localparam logic [2:0] OVC_ALL    = 3'h3;
    // event-in control encodings
    localparam logic [1:0] EIC_SYNC  = 2'h0;
    localparam logic [1:0] EIC_BREAK = 2'h1;
    localparam logic [1:0] EIC_NONE  = 2'h2;
    localparam logic [1:0] EIC_RSVD  = 2'h3;
    // debug mode states
    typedef enum logic [2:0] {
        DTCS_RUN = 3'b001,
        DTCS_OCD = 3'b010,
        DTCS_MON = 3'b100
    } dtcs_mode_t;
endpackage

/* File: design/dtcs_cause_if.sv */
`timescale 1ns/1ns
interface dtcs_cause_if;
    logic       enter;
    logic       leave;
    logic       tbf;
    logic       ext;
    logic       req;
    logic       zop;
    logic       sw_break_cause;
    logic       single_step_cause;
    logic [7:0] cmp;
    logic       sleep;
    logic       to_ocd;
    logic [31:0] causes;
    modport src (output enter, leave, tbf, ext, req, zop, sw_break_cause, single_step_cause, cmp, sleep, to_ocd,
                 input causes);
    modport dst (input enter, leave, tbf, ext, req, zop, sw_break_cause, single_step_cause, cmp, sleep, to_ocd,
                 output causes);
endinterface

/* File: design/dtcs_cause_latch.sv */
`timescale 1ns/1ns
module dtcs_cause_latch
    import dtcs_pkg::*;
(
    // clock and reset
    input  wire logic clk_sys_in,
    input  wire logic rst_n_in,
    // cause events
    dtcs_cause_if.dst cif
);
    logic [31:0] causes_r;
    logic [31:0] causes_nxt;

    always_comb begin
        causes_nxt = causes_r;
        if (cif.leave) begin
            causes_nxt = STS_RESET;
        end else if (cif.enter) begin
            causes_nxt = STS_RESET;
            causes_nxt[STS_TBF_BIT] = cif.tbf;
            causes_nxt[STS_EXB_BIT] = cif.ext;
            causes_nxt[STS_ACK_BIT] = cif.req;
            causes_nxt[STS_ZOP_BIT] = cif.zop;
            causes_nxt[STS_CMP_LSB +: 8] = cif.cmp;
            causes_nxt[STS_SLP_BIT] = cif.sleep & cif.to_ocd;
            causes_nxt[STS_HWB_BIT] = |cif.cmp;
            causes_nxt[STS_SWB_BIT] = cif.sw_break_cause;
            causes_nxt[STS_SSS_BIT] = cif.single_step_cause;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            causes_r <= STS_RESET;
        end else begin
            causes_r <= causes_nxt;
        end
    end

    assign cif.causes = causes_r;

    a_exit_clears: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        cif.leave |=> (causes_r == 32'h0))
        else $error("causes not cleared on exit");
    a_hwb_summary: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        causes_r[STS_HWB_BIT] == (|causes_r[STS_CMP_LSB +: 8]))
        else $error("hw break summary mismatch");
    a_multi_cause: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (cif.enter && !cif.leave && cif.sw_break_cause && cif.single_step_cause) |=>
        (causes_r[STS_SWB_BIT] && causes_r[STS_SSS_BIT]))
        else $error("simultaneous causes not all set");
endmodule

/* File: design/dtcs_top.sv */
`timescale 1ns/1ns
module dtcs_top
    import dtcs_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        rst_n_in,
    // debug port register access
    input  wire logic        ctl_wr_in,
    input  wire logic [31:0] ctl_wdata_in,
    output logic      [31:0] development_control_out,
    output logic      [31:0] development_status_out,
    // event-in pin, active low, asynchronous
    input  wire logic        event_in_pin_n_in,
    // cpu debug causes, valid with entry pulse
    input  wire logic        dbg_entry_in,
    input  wire logic        dbg_exit_in,
    input  wire logic        tbf_cause_in,
    input  wire logic        zop_cause_in,
    input  wire logic        swb_cause_in,
    input  wire logic        sss_cause_in,
    input  wire logic [7:0]  cmp_hit_in,
    input  wire logic        cpu_sleeping_in,
    input  wire logic        cpu_executing_in,
    // watchpoint trace start/stop pulses
    input  wire logic        wp_dt_start_in,
    input  wire logic        wp_dt_stop_in,
    input  wire logic        wp_bt_start_in,
    input  wire logic        wp_bt_stop_in,
    // trace message requests and queue state
    input  wire logic        msg_branch_in,
    input  wire logic        msg_data_in,
    input  wire logic        msg_own_in,
    input  wire logic        queue_full_in,
    // outputs to cpu and trace
    output logic             cpu_stall_out,
    output logic             overrun_msg_out,
    output logic             trace_sync_out,
    output logic             ext_break_out,
    output logic             ownership_trace_out,
    output logic             data_trace_out,
    output logic             branch_trace_out,
    output logic             monitor_mode_out
);
    logic [31:0] ctl_r,   ctl_nxt;
    logic [2:0]  evs_r,   evs_nxt;
    dtcs_mode_t  mode_r,  mode_nxt;
    logic        stall_r, stall_nxt;
    logic        ovr_r,   ovr_nxt;
    logic        sync_r,  sync_nxt;
    logic        brk_r,   brk_nxt;
    logic        extpend_r, extpend_nxt;
    logic        idle_r,  idle_nxt;
    logic [31:0] sts_r,   sts_nxt;
    logic        fall;
    logic [2:0]  tm;
    logic [2:0]  ovc;
    logic [1:0]  event_in_control;
    logic        dbe;
    logic        stall_br;
    logic        stall_dt;

    dtcs_cause_if cif ();

    dtcs_cause_latch u_latch (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (rst_n_in),
        .cif        (cif)
    );

    assign tm  = ctl_r[CTL_TM_LSB +: 3];
    assign ovc = ctl_r[CTL_OVC_LSB +: 3];
    assign event_in_control = ctl_r[CTL_EIC_LSB +: 2];
    assign dbe = ctl_r[CTL_DBE_BIT];
    // older third stage high, newer second stage low: high-to-low edge
    assign fall = evs_r[2] & ~evs_r[1];
    assign stall_br = (ovc == OVC_BR_OWN) || (ovc == OVC_ALL);
    assign stall_dt = (ovc == OVC_DT_OWN) || (ovc == OVC_ALL);

    assign cif.enter  = dbg_entry_in;
    assign cif.leave  = dbg_exit_in;
    assign cif.tbf    = tbf_cause_in;
    assign cif.ext    = extpend_r;
    assign cif.req    = ctl_r[CTL_DBR_BIT] | ctl_r[CTL_ABORT_BIT];
    assign cif.zop    = zop_cause_in & ctl_r[CTL_TOZ_BIT];
    assign cif.sw_break_cause    = swb_cause_in;
    assign cif.single_step_cause    = sss_cause_in;
    assign cif.cmp    = cmp_hit_in;
    assign cif.sleep  = cpu_sleeping_in;
    assign cif.to_ocd = ~ctl_r[CTL_MONSEL_BIT];

    always_comb begin
        ctl_nxt = ctl_r;
        if (ctl_wr_in) begin
            ctl_nxt = ctl_wdata_in & CTL_WMASK;
        end
        if (wp_dt_start_in) begin
            ctl_nxt[CTL_TM_LSB + 1] = 1'b1;
        end else if (wp_dt_stop_in) begin
            ctl_nxt[CTL_TM_LSB + 1] = 1'b0;
        end
        if (wp_bt_start_in) begin
            ctl_nxt[CTL_TM_LSB + 2] = 1'b1;
        end else if (wp_bt_stop_in) begin
            ctl_nxt[CTL_TM_LSB + 2] = 1'b0;
        end
        // request and abort self-clear on entry
        if (dbg_entry_in) begin
            ctl_nxt[CTL_DBR_BIT]   = 1'b0;
            ctl_nxt[CTL_ABORT_BIT] = 1'b0;
        end
    end

    always_comb begin
        evs_nxt  = {evs_r[1:0], event_in_pin_n_in};
        sync_nxt = 1'b0;
        brk_nxt  = 1'b0;
        extpend_nxt = extpend_r;
        if (fall) begin
            unique case (event_in_control)
                EIC_SYNC:  sync_nxt = (tm != 3'h0);
                EIC_BREAK: brk_nxt = dbe;
                EIC_NONE:  sync_nxt = 1'b0;
                EIC_RSVD:  sync_nxt = 1'b0;
            endcase
        end
        // pending external cause, consumed at entry; a new break wins
        if (brk_nxt) begin
            extpend_nxt = 1'b1;
        end else if (dbg_entry_in || dbg_exit_in) begin
            extpend_nxt = 1'b0;
        end
    end

    always_comb begin
        mode_nxt = mode_r;
        unique case (mode_r)
            DTCS_RUN: if (dbg_entry_in) begin
                mode_nxt = ctl_r[CTL_MONSEL_BIT] ? DTCS_MON : DTCS_OCD;
            end
            DTCS_OCD: if (dbg_exit_in) begin
                mode_nxt = DTCS_RUN;
            end
            DTCS_MON: if (dbg_exit_in) begin
                mode_nxt = DTCS_RUN;
            end
            default: mode_nxt = DTCS_RUN;
        endcase
        idle_nxt = (mode_nxt == DTCS_OCD) && !cpu_executing_in;
    end

    always_comb begin
        // overrun message when set to 000
        ovr_nxt = queue_full_in && (ovc == OVC_MSG)
                  && (msg_branch_in || msg_data_in || msg_own_in);
        stall_nxt = queue_full_in && (
                    (msg_own_in && (stall_br || stall_dt))
                    || (msg_branch_in && stall_br)
                    || (msg_data_in && stall_dt));
    end

    always_comb begin
        sts_nxt = cif.causes & STS_RMASK;
        sts_nxt[STS_OCD_BIT] = (mode_r == DTCS_OCD);
        sts_nxt[STS_INC_BIT] = idle_r;
        sts_nxt = sts_nxt & STS_RMASK;
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            ctl_r     <= CTL_RESET;
            evs_r     <= 3'h7;
            mode_r    <= DTCS_RUN;
            stall_r   <= 1'b0;
            ovr_r     <= 1'b0;
            sync_r    <= 1'b0;
            brk_r     <= 1'b0;
            extpend_r <= 1'b0;
            idle_r    <= 1'b0;
            sts_r     <= STS_RESET;
        end else begin
            ctl_r     <= ctl_nxt;
            evs_r     <= evs_nxt;
            mode_r    <= mode_nxt;
            stall_r   <= stall_nxt;
            ovr_r     <= ovr_nxt;
            sync_r    <= sync_nxt;
            brk_r     <= brk_nxt;
            extpend_r <= extpend_nxt;
            idle_r    <= idle_nxt;
            sts_r     <= sts_nxt;
        end
    end

    assign development_control_out = ctl_r;
    assign development_status_out  = sts_r;
    assign cpu_stall_out           = stall_r;
    assign overrun_msg_out         = ovr_r;
    assign trace_sync_out          = sync_r;
    assign ext_break_out           = brk_r;
    assign ownership_trace_out     = ctl_r[CTL_TM_LSB];
    assign data_trace_out          = ctl_r[CTL_TM_LSB + 1];
    assign branch_trace_out        = ctl_r[CTL_TM_LSB + 2];
    // one-hot monitor state bit
    assign monitor_mode_out        = mode_r[2];

    // control and status checks
    a_overrun_msg: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (queue_full_in && ovc == OVC_MSG && msg_data_in) |=> (ovr_r && !stall_r))
        else $error("overrun message missing");
    a_stall_class: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (queue_full_in && ovc == OVC_DT_OWN && msg_branch_in && !msg_data_in && !msg_own_in)
        |=> !stall_r)
        else $error("stall on branch at data-only setting");
    a_stall_data: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (queue_full_in && ovc == OVC_ALL && msg_data_in) |=> stall_r)
        else $error("no stall with all classes");
    a_evt_nosync: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (fall && tm == 3'h0) |=> !sync_r)
        else $error("sync without trace enabled");
    a_evt_break: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (fall && event_in_control == EIC_BREAK && dbe) |=> brk_r ##1 !brk_r)
        else $error("event break pulse wrong");
    a_sts_reserved: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (development_status_out & ~STS_RMASK) == 32'h0)
        else $error("reserved status bits set");
    a_ocd_flag: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (mode_r == DTCS_MON) |=> !development_status_out[STS_OCD_BIT])
        else $error("ocd flag set in monitor mode");
    a_mode_select: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (mode_r == DTCS_RUN && dbg_entry_in && ctl_r[CTL_MONSEL_BIT]) |=>
        (mode_r == DTCS_MON) ##1 monitor_mode_out)
        else $error("monitor select not applied at entry");
    a_wp_trace: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (wp_bt_start_in && !dbg_entry_in) |=> branch_trace_out)
        else $error("watchpoint did not enable branch trace");
    a_idle_flag: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        development_status_out[STS_INC_BIT] |-> $past(idle_r))
        else $error("idle flag without ocd idle");

    // event-in pin checks
    a_sync_pulse: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (fall && event_in_control == EIC_SYNC && tm != 3'h0) |=> (trace_sync_out && !ext_break_out))
        else $error("trace sync pulse missing");
    a_evt_idle: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (fall && (event_in_control == EIC_NONE || event_in_control == EIC_RSVD)) |=> (!trace_sync_out && !ext_break_out))
        else $error("event action on no-operation code");
    a_evt_nobreak: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (fall && event_in_control == EIC_BREAK && !dbe) |=> !ext_break_out)
        else $error("break without debug enable");
    a_evt_quiet: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        !fall |=> (!trace_sync_out && !ext_break_out))
        else $error("event pulse without falling edge");

    // trace queue checks
    a_stall_brown: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (queue_full_in && ovc == OVC_BR_OWN && (msg_branch_in || msg_own_in)) |=> cpu_stall_out)
        else $error("no stall for branch or ownership");
    a_stall_dtown: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (queue_full_in && ovc == OVC_DT_OWN && (msg_data_in || msg_own_in)) |=> cpu_stall_out)
        else $error("no stall for data or ownership");
    a_stall_free: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        !queue_full_in |=> (!cpu_stall_out && !overrun_msg_out))
        else $error("stall or overrun with queue free");
    a_ovr_only_msg: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (ovc != OVC_MSG) |=> !overrun_msg_out)
        else $error("overrun message with stall setting");

    // watchpoint checks
    a_wp_dt_start: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        wp_dt_start_in |=> data_trace_out)
        else $error("watchpoint did not enable data trace");
    a_wp_dt_stop: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (wp_dt_stop_in && !wp_dt_start_in) |=> !data_trace_out)
        else $error("watchpoint did not stop data trace");
    a_wp_bt_stop: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (wp_bt_stop_in && !wp_bt_start_in) |=> !branch_trace_out)
        else $error("watchpoint did not stop branch trace");

    // debug entry and exit checks
    a_req_clear: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        dbg_entry_in |=> (!development_control_out[CTL_DBR_BIT]
                          && !development_control_out[CTL_ABORT_BIT]))
        else $error("request bits not cleared at entry");
    a_ocd_enter: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (mode_r == DTCS_RUN && dbg_entry_in && !ctl_r[CTL_MONSEL_BIT]) |=>
        ##1 development_status_out[STS_OCD_BIT])
        else $error("ocd flag not set after entry");
    a_ext_cause: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (dbg_entry_in && !dbg_exit_in && extpend_r) |=>
        ##1 development_status_out[STS_EXB_BIT])
        else $error("external cause not reported");
    a_zop_cause: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (dbg_entry_in && !dbg_exit_in && zop_cause_in && ctl_r[CTL_TOZ_BIT]) |=>
        ##1 development_status_out[STS_ZOP_BIT])
        else $error("zero opcode cause not reported");
    a_tbf_cause: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (dbg_entry_in && !dbg_exit_in && tbf_cause_in) |=>
        ##1 development_status_out[STS_TBF_BIT])
        else $error("buffer full cause not reported");
    a_sleep_mon: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (dbg_entry_in && !dbg_exit_in && ctl_r[CTL_MONSEL_BIT]) |=>
        ##1 !development_status_out[STS_SLP_BIT])
        else $error("sleep flag set on monitor entry");
    a_idle_mon: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (mode_r == DTCS_MON) |=> ##1 !development_status_out[STS_INC_BIT])
        else $error("idle flag set outside ocd");
    a_exit_mode: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        dbg_exit_in |=> (mode_r == DTCS_RUN && !monitor_mode_out))
        else $error("mode not left at exit");
endmodule

/* File: dv/dtcs_dbg_model.sv */
`timescale 1ns/1ns
module dtcs_dbg_model
    import dtcs_pkg::*;
(
    // clock
    input  wire logic        clk_sys_in,
    // register port
    output logic             ctl_wr_out,
    output logic      [31:0] ctl_wdata_out
);
    initial begin
        ctl_wr_out    = 1'b0;
        ctl_wdata_out = 32'h00000000;
    end

    task automatic write_ctl(input logic [31:0] v);
        @(posedge clk_sys_in);
        ctl_wr_out    <= 1'b1;
        ctl_wdata_out <= {v[31:8], 1'b0, v[6:0]};
        @(posedge clk_sys_in);
        ctl_wr_out    <= 1'b0;
        ctl_wdata_out <= ~v;
    endtask

    function automatic logic [31:0] view(input logic in_dbg, input logic [31:0] s);
        return in_dbg ? s : 32'h00000000;
    endfunction
endmodule

/* File: dv/tb_top.sv */
`timescale 1ns/1ns
module tb_top
    import dtcs_pkg::*;
;
    logic        clk_sys_in, rst_n_in, event_in_pin_n_in, dbg_entry_in, dbg_exit_in;
    logic        tbf_cause_in, zop_cause_in, swb_cause_in, sss_cause_in;
    logic        cpu_sleeping_in, cpu_executing_in, queue_full_in;
    logic        wp_dt_start_in, wp_dt_stop_in, wp_bt_start_in, wp_bt_stop_in;
    logic        msg_branch_in, msg_data_in, msg_own_in, ctl_wr;
    logic [7:0]  cmp_hit_in;
    logic [31:0] ctl_wdata, development_control_out, development_status_out;
    logic        cpu_stall_out, overrun_msg_out, trace_sync_out, ext_break_out;
    logic        ownership_trace_out, data_trace_out, branch_trace_out, monitor_mode_out;
    logic [31:0] ctl_exp, ns, nb;
    logic        ext_pend;
    int          n_errors, check_count;

    dtcs_dbg_model dbg (.clk_sys_in, .ctl_wr_out(ctl_wr), .ctl_wdata_out(ctl_wdata));
    dtcs_top dut (.clk_sys_in, .rst_n_in, .ctl_wr_in(ctl_wr), .ctl_wdata_in(ctl_wdata),
        .development_control_out, .development_status_out, .event_in_pin_n_in,
        .dbg_entry_in, .dbg_exit_in, .tbf_cause_in, .zop_cause_in, .swb_cause_in,
        .sss_cause_in, .cmp_hit_in, .cpu_sleeping_in, .cpu_executing_in, .wp_dt_start_in,
        .wp_dt_stop_in, .wp_bt_start_in, .wp_bt_stop_in, .msg_branch_in, .msg_data_in,
        .msg_own_in, .queue_full_in, .cpu_stall_out, .overrun_msg_out, .trace_sync_out,
        .ext_break_out, .ownership_trace_out, .data_trace_out, .branch_trace_out,
        .monitor_mode_out);

    always #5 clk_sys_in = ~clk_sys_in;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [31:0] v);
        dbg.write_ctl(v);
        ctl_exp = {v[31:8], 1'b0, v[6:0]} & CTL_WMASK;
        #1;
        check(development_control_out, ctl_exp);
        check({branch_trace_out, data_trace_out, ownership_trace_out}, ctl_exp[2:0]);
    endtask

    task automatic drive_causes(input logic [31:0] r);
        {tbf_cause_in, zop_cause_in, cpu_sleeping_in} <= {r[0], r[1], r[3]};
        {swb_cause_in, sss_cause_in, cmp_hit_in} <= {r[4], r[5], r[15:8]};
    endtask

    task automatic enter(input logic [31:0] r);
        logic        mm;
        logic [31:0] e;
        mm = ctl_exp[29];
        e = {3'h0, r[0], ext_pend, ctl_exp[12] | ctl_exp[31], r[1] & ctl_exp[25],
             ~mm & ~r[2], 8'h00, r[15:8], 2'h0, ~mm, ~mm & r[3], 1'b0, |r[15:8], r[4], r[5]};
        @(posedge clk_sys_in);
        dbg_entry_in     <= 1'b1;
        cpu_executing_in <= r[2];
        drive_causes(r);
        @(posedge clk_sys_in);
        dbg_entry_in <= 1'b0;
        drive_causes(~r);
        repeat (3) @(posedge clk_sys_in);
        #1;
        check(dbg.view(1'b1, development_status_out), e);
        check(monitor_mode_out, mm);
        ctl_exp[31] = 1'b0;
        ctl_exp[12] = 1'b0;
        ext_pend    = 1'b0;
        check(development_control_out, ctl_exp);
        wr(ctl_exp ^ 32'h20000000);
        check(development_status_out, e);
        check(monitor_mode_out, mm);
        @(posedge clk_sys_in);
        dbg_exit_in <= 1'b1;
        @(posedge clk_sys_in);
        dbg_exit_in <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
        #1;
        check(development_status_out, 32'h00000000);
        check(monitor_mode_out, 1'b0);
    endtask

    initial begin
        {clk_sys_in, rst_n_in, dbg_entry_in, dbg_exit_in, ctl_exp, ext_pend} = '0;
        {tbf_cause_in, zop_cause_in, swb_cause_in, sss_cause_in, cmp_hit_in} = '0;
        {cpu_sleeping_in, cpu_executing_in, queue_full_in} = '0;
        {wp_dt_start_in, wp_dt_stop_in, wp_bt_start_in, wp_bt_stop_in} = '0;
        {msg_branch_in, msg_data_in, msg_own_in} = '0;
        event_in_pin_n_in = 1'b1;
        n_errors = 0;
        check_count = 0;
        void'($urandom(88));
        repeat (6) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        @(posedge clk_sys_in);
        #1;
        check(development_control_out, 32'h00000000);
        check(development_status_out, 32'h00000000);
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            wr({18'h0, i[3], 8'h00, i[1:0], {3{i[2]}}});
            @(posedge clk_sys_in);
            event_in_pin_n_in <= 1'b0;
            ns = 0;
            nb = 0;
            repeat (10) begin
                @(posedge clk_sys_in);
                #1;
                ns = ns + trace_sync_out;
                nb = nb + ext_break_out;
            end
            check(ns, i[1:0] == 2'h0 && i[2]);
            check(nb, i[1:0] == 2'h1 && i[3]);
            if (i[1:0] == 2'h1 && i[3]) ext_pend = 1'b1;
            @(posedge clk_sys_in);
            event_in_pin_n_in <= 1'b1;
            repeat (5) @(posedge clk_sys_in);
        end
        $display("test event pin done");
        wr(32'h00000000);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_sys_in);
            {wp_dt_start_in, wp_bt_start_in, wp_dt_stop_in, wp_bt_stop_in} <= 4'b1000 >> k;
            @(posedge clk_sys_in);
            {wp_dt_start_in, wp_bt_start_in, wp_dt_stop_in, wp_bt_stop_in} <= 4'b0000;
            #1;
            ctl_exp[1 + k % 2] = (k < 2);
            check(development_control_out, ctl_exp);
            check({branch_trace_out, data_trace_out, ownership_trace_out}, ctl_exp[2:0]);
        end
        $display("test watchpoint done");
        for (int o = 0; o < 4; o++) begin
            wr(32'h00000007 | (o << 5));
            for (int m = 0; m < 3; m++) begin
                for (int f = 0; f < 2; f++) begin
                    @(posedge clk_sys_in);
                    queue_full_in <= f[0];
                    {msg_branch_in, msg_data_in, msg_own_in} <= 3'b100 >> m;
                    @(posedge clk_sys_in);
                    {msg_branch_in, msg_data_in, msg_own_in} <= 3'b000;
                    queue_full_in <= 1'b0;
                    #1;
                    check(overrun_msg_out, f == 1 && o == 0);
                    check(cpu_stall_out,
                          f == 1 && (o == 3 || (o == 1 && m != 1) || (o == 2 && m != 0)));
                    repeat (2) @(posedge clk_sys_in);
                end
            end
        end
        $display("test overrun done");
        repeat (12) begin
            wr($urandom);
            enter($urandom);
        end
        enter(32'h0000ffff);
        $display("test debug entry done");
        end_of_test();
    end
endmodule
